//--- ddr4_conv_checker.sv
`timescale 1ns/1ps
module ddr4_conv_checker (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic REQ_VALID,
  input wire logic REQ_READY,
  input ddr4_conv_pkg::cfg_s CFG,
  input wire logic RES_VALID,
  input ddr4_conv_pkg::res_s RES,
  input ddr4_conv_pkg::policy_s POLICY
);
  import ddr4_conv_pkg::*;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  sequence s_take;
    REQ_VALID && REQ_READY;
  endsequence
  sequence s_busy;
    (!REQ_READY && !RES_VALID) [*8];
  endsequence
  a_res_lat: assert property (s_take |-> ##50 RES_VALID) else $error("result late");
  a_busy_hold: assert property (s_take |=> s_busy) else $error("ready early");
  a_pulse_one: assert property (RES_VALID |=> !RES_VALID && REQ_READY) else $error("pulse long");
  a_res_hold: assert property (!RES_VALID |-> $stable(RES)) else $error("result moved");
  a_err_sat: assert property (RES_VALID && RES.err |-> RES.count == 16'hFFFF) else $error("no clamp");
  a_wr_start: assert property (!$past(RST) |-> POLICY.wr_start == $past(CFG.wl) +
    ($past(CFG.bc4_fixed) ? WR_START_BC4_FIXED : WR_START_BURST)) else $error("write start");
  a_wtr_pick: assert property (!$past(RST) |-> POLICY.wtr ==
    ($past(CFG.crc_en || CFG.dm_en) ? $past(CFG.wtr_long) : $past(CFG.wtr_short))) else $error("wtr");
  a_pda_pick: assert property (!$past(RST) |-> POLICY.pda_use_ds_dh == $past(CFG.pda_low_bl8)) else $error("pda");
  a_tck_round: assert property (!$past(RST) |->
    POLICY.tck_ps == 16'(($past(CFG.tck_fs) + FS_HALF) / FS_PER_PS)) else $error("tck round");
endmodule : ddr4_conv_checker
bind ddr4_timing_conv ddr4_conv_checker u_chk (.SYS_CLK(SYS_CLK), .RST(RST), .REQ_VALID(REQ_VALID),
  .REQ_READY(REQ_READY), .CFG(CFG), .RES_VALID(RES_VALID), .RES(RES), .POLICY(POLICY));

//--- ddr4_conv_pkg.sv
package ddr4_conv_pkg;
  // datapath widths
  localparam int DIV_W = 48;
  localparam int CNT_W = 16;
  localparam int STEP_W = 6;
  // conversion constants
  localparam logic [9:0] PS_SCALE = 10'h3E8;
  localparam logic [9:0] SPD_INV_ADJ = 10'h3CE;
  localparam logic [9:0] FS_PER_PS = 10'h3E8;
  localparam logic [9:0] FS_HALF = 10'h1F4;
  localparam logic [15:0] CAL_MIN_PS = 16'h0EA4;
  localparam logic [15:0] CAL_MIN_CK = 16'h0003;
  localparam logic [7:0] WR_START_BURST = 8'h04;
  localparam logic [7:0] WR_START_BC4_FIXED = 8'h02;
  localparam logic [STEP_W-1:0] LAST_STEP = 6'h2F;

  // kind of conversion asked for
  typedef enum logic [3:0] {
    KIND_SPD = 4'b0001,
    KIND_NONSPD = 4'b0010,
    KIND_CAL = 4'b0100,
    KIND_RFC = 4'b1000
  } kind_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_DIV = 4'b0010,
    ST_FIN = 4'b0100,
    ST_OUT = 4'b1000
  } state_e;

  typedef struct packed {
    kind_e kind;
    logic [31:0] param_ps;
  } req_s;

  typedef struct packed {
    logic [23:0] tck_fs;
    logic [7:0] wl;
    logic [7:0] pl;
    logic bc4_fixed;
    logic parity_en;
    logic dll_off;
    logic crc_en;
    logic dm_en;
    logic pda_low_bl8;
    logic [7:0] wtr_short;
    logic [7:0] wtr_long;
  } cfg_s;

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic err;
  } res_s;

  typedef struct packed {
    logic [7:0] wr_start;
    logic [7:0] wtr;
    logic pda_use_ds_dh;
    logic [15:0] tck_ps;
  } policy_s;
endpackage : ddr4_conv_pkg

//--- ddr4_sched_model.sv
`timescale 1ns/1ps
module ddr4_sched_model (
  // result side of the converter
  input wire logic clk,
  input wire logic res_valid,
  input ddr4_conv_pkg::res_s res,
  // count handed to the command scheduler
  output logic [15:0] last_count
);
  import ddr4_conv_pkg::*;
  // per-frequency values arrive as plain requests, so the scheduler keeps only the last count
  always_ff @(posedge clk) if (res_valid) last_count <= res.count;
endmodule : ddr4_sched_model

//--- ddr4_timing_conv.sv
// What this block does
// - listed parameters use ceiling of ns over tCK
// - CAL minimum is max of 3 clocks, 3.748ns
// - parity with DLL off adds PL to tRFC
// - pick write-to-read delay by CRC and DM
// - PDA checks use tDS/tDH when low whole burst
// - tCCD_L, tDLLK use per-frequency value
// - clock period held to nearest picosecond
// - SPD count is ceiling of quotient minus 0.025
// - integer form: ps*1000/tCK plus 974, over 1000
// - non-SPD count is plain ceiling, no adjustment
`timescale 1ns/1ps
module ddr4_timing_conv (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // conversion request
  input wire logic REQ_VALID,
  input ddr4_conv_pkg::req_s REQ,
  output logic REQ_READY,
  // operating configuration
  input ddr4_conv_pkg::cfg_s CFG,
  // conversion result
  output logic RES_VALID,
  output ddr4_conv_pkg::res_s RES,
  // derived scheduling values
  output ddr4_conv_pkg::policy_s POLICY
);
  import ddr4_conv_pkg::*;

  state_e state, next_state;
  kind_e kind, next_kind;
  logic [15:0] tck_ps, next_tck_ps;
  logic [DIV_W-1:0] quo, next_quo;
  logic [DIV_W-1:0] rem, next_rem;
  logic [STEP_W-1:0] step, next_step;
  res_s res, next_res;
  policy_s policy, next_policy;

  // femtosecond period rounded half up to whole picoseconds
  function automatic logic [15:0] round_ps(input logic [23:0] fs);
    logic [24:0] sum;
    logic [24:0] q;
    sum = {1'b0, fs} + {15'h0000, FS_HALF};
    q = sum / {15'h0000, FS_PER_PS};
    return (q > 25'h000FFFF) ? 16'hFFFF : q[15:0];
  endfunction : round_ps

  // clamp a wide count to the result width instead of wrapping
  function automatic logic [CNT_W-1:0] sat(input logic [DIV_W-1:0] x);
    return (x > DIV_W'({CNT_W{1'b1}})) ? {CNT_W{1'b1}} : x[CNT_W-1:0];
  endfunction : sat

  // handshakes decoded straight from state
  assign REQ_READY = (state == ST_IDLE);
  assign RES_VALID = (state == ST_OUT);
  assign RES = res;
  assign POLICY = policy;

  // conversion sequencer: restoring divider, one quotient bit per clock
  always_comb begin
    logic [DIV_W-1:0] rem_sh;
    logic [DIV_W-1:0] ceil_q;
    logic [DIV_W-1:0] spd_sum;
    logic [DIV_W-1:0] wide;
    rem_sh = '0;
    ceil_q = '0;
    spd_sum = '0;
    wide = '0;
    next_state = state;
    next_kind = kind;
    next_tck_ps = tck_ps;
    next_quo = quo;
    next_rem = rem;
    next_step = step;
    next_res = res;
    case (state)
      ST_IDLE: begin
        if (REQ_VALID) begin
          next_kind = REQ.kind;
          next_tck_ps = round_ps(CFG.tck_fs);
          next_rem = '0;
          next_step = '0;
          case (REQ.kind)
            // 48-bit product cannot overflow for any 32-bit ps value
            KIND_SPD: next_quo = DIV_W'(REQ.param_ps) * DIV_W'(PS_SCALE);
            KIND_CAL: next_quo = DIV_W'(CAL_MIN_PS);
            default: next_quo = DIV_W'(REQ.param_ps);
          endcase
          next_state = ST_DIV;
        end
      end
      ST_DIV: begin
        rem_sh = {rem[DIV_W-2:0], quo[DIV_W-1]};
        next_quo = {quo[DIV_W-2:0], 1'b0};
        if (rem_sh >= DIV_W'(tck_ps)) begin
          next_rem = rem_sh - DIV_W'(tck_ps);
          next_quo[0] = 1'b1;
        end else begin
          next_rem = rem_sh;
        end
        next_step = step + 6'h01;
        if (step == LAST_STEP) begin
          next_state = ST_FIN;
        end
      end
      ST_FIN: begin
        // ceiling of the quotient, no adjustment factor
        ceil_q = quo + DIV_W'(rem != '0);
        case (kind)
          KIND_SPD: begin
            // same as ceiling of quotient minus 0.025, without fractions
            spd_sum = quo + DIV_W'(SPD_INV_ADJ);
            wide = spd_sum / DIV_W'(PS_SCALE);
          end
          KIND_CAL: wide = (ceil_q > DIV_W'(CAL_MIN_CK)) ? ceil_q : DIV_W'(CAL_MIN_CK);
          KIND_RFC: wide = ceil_q + ((CFG.parity_en && CFG.dll_off) ? DIV_W'(CFG.pl) : '0);
          // per-frequency tCCD_L and tDLLK arrive here as plain ps values
          default: wide = ceil_q;
        endcase
        // a zero period gives a quotient that may wrap on the ceiling step, so pin the count
        next_res.count = (tck_ps == 16'h0000) ? {CNT_W{1'b1}} : sat(wide);
        next_res.err = (tck_ps == 16'h0000);
        next_state = ST_OUT;
      end
      ST_OUT: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      state <= ST_IDLE;
      kind <= KIND_NONSPD;
      tck_ps <= 16'h0000;
      quo <= '0;
      rem <= '0;
      step <= '0;
      res <= '0;
    end else begin
      state <= next_state;
      kind <= next_kind;
      tck_ps <= next_tck_ps;
      quo <= next_quo;
      rem <= next_rem;
      step <= next_step;
      res <= next_res;
    end
  end

  // scheduling values follow configuration every clock
  always_comb begin
    next_policy.wr_start = CFG.wl + (CFG.bc4_fixed ? WR_START_BC4_FIXED : WR_START_BURST);
    // only both-on and both-off are defined; a mixed setting takes the longer delay
    next_policy.wtr = (!CFG.crc_en && !CFG.dm_en) ? CFG.wtr_short : CFG.wtr_long;
    next_policy.pda_use_ds_dh = CFG.pda_low_bl8;
    next_policy.tck_ps = round_ps(CFG.tck_fs);
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      policy <= '0;
    end else begin
      policy <= next_policy;
    end
  end
endmodule : ddr4_timing_conv

//--- tb_ddr4_timing_to_clock_converter.sv
`timescale 1ns/1ps
module tb_ddr4_timing_to_clock_converter;
  import ddr4_conv_pkg::*;
  logic SYS_CLK = 0, RST = 1, REQ_VALID = 0, REQ_READY, RES_VALID;
  req_s REQ = '0;
  cfg_s CFG = '0;
  res_s RES;
  policy_s POLICY;
  logic [16:0] expq[$];
  logic [15:0] last_count;
  int n_fail = 0, n_tests = 0;
  ddr4_timing_conv u_dut (.SYS_CLK(SYS_CLK), .RST(RST), .REQ_VALID(REQ_VALID), .REQ(REQ),
    .REQ_READY(REQ_READY), .CFG(CFG), .RES_VALID(RES_VALID), .RES(RES), .POLICY(POLICY));
  ddr4_sched_model u_sched (.clk(SYS_CLK), .res_valid(RES_VALID), .res(RES), .last_count(last_count));
  // 50 MHz clock
  initial forever #10 SYS_CLK = ~SYS_CLK;
  task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk
  // wide arithmetic so ps times 1000 never wraps
  function automatic logic [16:0] exp_res(kind_e k, logic [31:0] ps);
    logic [63:0] t, n;
    t = (64'(CFG.tck_fs) + FS_HALF) / FS_PER_PS;
    if (t == 64'h0) return {16'hFFFF, 1'b1};
    case (k)
      KIND_SPD: n = ((64'(ps) * PS_SCALE) / t + SPD_INV_ADJ) / PS_SCALE;
      KIND_CAL: n = (CAL_MIN_PS + t - 64'h1) / t;
      default: n = (64'(ps) + t - 64'h1) / t + (k == KIND_RFC && CFG.parity_en && CFG.dll_off ? CFG.pl : 8'h00);
    endcase
    if (k == KIND_CAL && n < CAL_MIN_CK) n = CAL_MIN_CK;
    return {(n > 64'hFFFF) ? 16'hFFFF : n[15:0], 1'b0};
  endfunction : exp_res
  task automatic conv(input kind_e k, input logic [31:0] ps);
    logic [16:0] e;
    e = exp_res(k, ps);
    REQ_VALID <= 1'b1;
    REQ <= '{k, ps};
    expq.push_back(e);
    @(negedge SYS_CLK);
    REQ_VALID <= 1'b0;
    repeat (60) if (!REQ_READY) @(negedge SYS_CLK);
    // the scheduler must be left holding the count it was handed
    chk(17'(last_count), 17'(e[16:1]));
  endtask : conv
  task automatic pol;
    repeat (2) @(negedge SYS_CLK);
    // the start field is eight bits wide, so a large latency wraps
    chk(17'(POLICY.wr_start), 17'(8'(CFG.wl + (CFG.bc4_fixed ? 8'h02 : 8'h04))));
    chk(17'(POLICY.wtr), 17'(CFG.crc_en | CFG.dm_en ? CFG.wtr_long : CFG.wtr_short));
    chk(17'(POLICY.pda_use_ds_dh), 17'(CFG.pda_low_bl8));
    chk(17'(POLICY.tck_ps), 17'((CFG.tck_fs + 24'h0001F4) / 24'h0003E8));
  endtask : pol
  // results are matched in order against what the driver noted
  always @(negedge SYS_CLK) if (RES_VALID === 1'b1) chk(RES, expq.pop_front());
  task automatic summarize;
    // a result that never came back is a failure, not a silent pass
    if (expq.size() != 0) n_fail++;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  // every flag pattern, kinds in turn, random period and parameter
  initial begin
    void'($urandom(5));
    repeat (8) @(negedge SYS_CLK);
    RST <= 1'b0;
    for (int i = 0; i < 64; i++) begin
      CFG <= {24'h0B0000 + 24'($urandom % 32'h40000), 8'($urandom), 8'($urandom), 6'(i), 16'($urandom)};
      pol();
      conv(kind_e'(4'h1 << (i % 4)), $urandom % 32'h30000);
    end
    // slow clock so the three-clock floor of the latency wins
    CFG.tck_fs <= 24'h1E8480;
    pol();
    conv(KIND_CAL, 32'h00000000);
    CFG.tck_fs <= 24'h0001F3;
    pol();
    conv(KIND_NONSPD, 32'h00000064);
    summarize();
  end
  // a hang costs about 10000 cycles at most
  initial begin
    #200000;
    n_fail++;
    summarize();
  end
endmodule : tb_ddr4_timing_to_clock_converter
